/* File: pio_pkg.sv */
`default_nettype none
package pio_pkg;
	localparam int PIO_PORTS = 5;
	localparam int PIO_W = 8;
	localparam int PIO_ADDR_W = 12;
	// Port order in every array: 0=A 1=B 2=C 3=D 4=E
	localparam int PIO_A = 0;
	localparam int PIO_C = 2;
	localparam int PIO_E = 4;
	// Register indices; byte address is four times the index
	localparam logic [PIO_PORTS-1:0][3:0] PIO_DATA_IDX = {4'h8, 4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [PIO_PORTS-1:0][3:0] PIO_DIR_IDX = {4'hc, 4'h7, 4'h6, 4'h5, 4'h4};
	localparam logic [PIO_PORTS-1:0][3:0] PIO_PUE_IDX = {4'h0, 4'hf, 4'h0, 4'he, 4'hd};
	localparam logic [PIO_PORTS-1:0] PIO_HAS_PUE = 5'h0d;
	// Implemented bits of each port
	localparam logic [PIO_PORTS-1:0][PIO_W-1:0] PIO_MASK = {8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff};
	// Unimplemented data bits that read back as one
	localparam logic [PIO_PORTS-1:0][PIO_W-1:0] PIO_DATA_SET = {8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
	localparam logic [PIO_W-1:0] PIO_DIR_RST = 8'h00;
	localparam logic [PIO_W-1:0] PIO_PUE_RST = 8'h00;
	localparam logic [PIO_W-1:0] PIO_OEN_RST = 8'hff;
	localparam logic [PIO_W-1:0] PIO_ZERO8 = 8'h00;
	localparam logic [31:0] PIO_ZERO32 = 32'h0000_0000;
	localparam logic [1:0] PIO_ALIGN = 2'h0;

	typedef struct packed
	{
		logic [PIO_W-1:0] out;
		logic [PIO_W-1:0] oe_n;
		logic [PIO_W-1:0] pull;
	} pio_pad_s;

	typedef struct packed
	{
		logic [PIO_W-1:0] latch;
		logic [PIO_W-1:0] dir;
		logic [PIO_W-1:0] pue;
		logic [PIO_W-1:0] oe_n;
		logic [PIO_W-1:0] pull;
		logic [PIO_W-1:0] sync1;
		logic [PIO_W-1:0] sync2;
	} pio_port_s;

	typedef struct packed
	{
		pio_port_s [PIO_PORTS-1:0] port;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pio_state_s;
endpackage : pio_pkg
`default_nettype wire

/* File: pio_ports.sv */
`default_nettype none
module pio_ports
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pio_pkg::PIO_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pio_pkg::PIO_PORTS-1:0][pio_pkg::PIO_W-1:0] pin_in,
	output pio_pkg::pio_pad_s [pio_pkg::PIO_PORTS-1:0] pads
);
	import pio_pkg::*;

	pio_state_s state_reg;
	pio_state_s state_next;
	logic addr_ok;
	logic [3:0] idx;

	assign idx = paddr[5:2];
	assign addr_ok = (paddr[1:0] == PIO_ALIGN) &&
		(paddr[PIO_ADDR_W-1:6] == '0);

	always_comb
	begin
		logic setup;
		logic wr;
		logic hit;
		logic [PIO_W-1:0] rd;
		logic [PIO_W-1:0] m;
		setup = 1'b0;
		wr = 1'b0;
		hit = 1'b0;
		rd = PIO_ZERO8;
		m = PIO_ZERO8;
		state_next = state_reg;
		state_next.pready = 1'b0;
		// One setup cycle, one access cycle; pready ends the access
		setup = psel && !penable && !state_reg.pready;
		// Writes land only at the edge that completes the access
		wr = psel && penable && state_reg.pready && pwrite &&
			!state_reg.pslverr && pstrb[0];
		for (int p = 0; p < PIO_PORTS; p++)
		begin
			state_next.port[p].sync1 = pin_in[p];
			state_next.port[p].sync2 = state_reg.port[p].sync1;
		end
		if (setup)
		begin
			for (int p = 0; p < PIO_PORTS; p++)
			begin
				m = PIO_MASK[p];
				if (!addr_ok)
				begin
					hit = hit;
				end
				else if (idx == PIO_DATA_IDX[p])
				begin
					hit = 1'b1;
					// Output bits read the latch, input bits the synchronised pin
					rd = ((state_reg.port[p].latch & state_reg.port[p].dir) |
						(state_reg.port[p].sync2 & ~state_reg.port[p].dir)) & m |
						PIO_DATA_SET[p];
				end
				else if (idx == PIO_DIR_IDX[p])
				begin
					hit = 1'b1;
					rd = state_reg.port[p].dir & m;
				end
				else if (PIO_HAS_PUE[p] && idx == PIO_PUE_IDX[p])
				begin
					hit = 1'b1;
					rd = state_reg.port[p].pue & m;
				end
			end
			state_next.prdata = {24'h00_0000, rd};
			state_next.pready = 1'b1;
			state_next.pslverr = !hit;
		end
		if (wr)
		begin
			for (int p = 0; p < PIO_PORTS; p++)
			begin
				m = PIO_MASK[p];
				if (idx == PIO_DATA_IDX[p])
				begin
					// Latch updates whatever the direction
					state_next.port[p].latch = pwdata[PIO_W-1:0] & m;
				end
				else if (idx == PIO_DIR_IDX[p])
				begin
					state_next.port[p].dir = pwdata[PIO_W-1:0] & m;
				end
				else if (PIO_HAS_PUE[p] && idx == PIO_PUE_IDX[p])
				begin
					state_next.port[p].pue = pwdata[PIO_W-1:0] & m;
				end
			end
		end
		// Pad controls follow the new direction at the same edge as the write
		for (int p = 0; p < PIO_PORTS; p++)
		begin
			state_next.port[p].oe_n = ~state_next.port[p].dir;
			state_next.port[p].pull = state_next.port[p].pue & ~state_next.port[p].dir;
		end
	end

	// Latches get no reset value: they keep their contents through reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < PIO_PORTS; p++)
			begin
				state_reg.port[p].dir <= PIO_DIR_RST;
				state_reg.port[p].pue <= PIO_PUE_RST;
				state_reg.port[p].oe_n <= PIO_OEN_RST;
				state_reg.port[p].pull <= PIO_ZERO8;
				state_reg.port[p].sync1 <= PIO_ZERO8;
				state_reg.port[p].sync2 <= PIO_ZERO8;
			end
			state_reg.prdata <= PIO_ZERO32;
			state_reg.pready <= 1'b0;
			state_reg.pslverr <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;

	// Software should load the latch before setting direction, else the old value drives
	always_comb
	begin
		for (int p = 0; p < PIO_PORTS; p++)
		begin
			pads[p].out = state_reg.port[p].latch;
			pads[p].oe_n = state_reg.port[p].oe_n;
			pads[p].pull = state_reg.port[p].pull;
		end
	end
endmodule : pio_ports
`default_nettype wire

/* File: pio_pins.sv */
`default_nettype none
module pio_pins
(
	input wire pio_pkg::pio_pad_s [4:0] pads,
	input wire logic [39:0] ext,
	output logic [39:0] pin_in
);
	timeunit 1ns / 1ps;
	// Board leaves inputs weak, so an enabled pullup wins
	always_comb for (int p = 0; p < 5; p++)
		pin_in[p*8+:8] = ~pads[p].oe_n & pads[p].out
			| pads[p].oe_n & (pads[p].pull | ext[p*8+:8]);
endmodule : pio_pins
`default_nettype wire

/* File: pio_ports_chk.sv */
`default_nettype none
module pio_ports_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire pio_pkg::pio_pad_s [4:0] pads
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rdy_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_rdy_pulse: assert property (pready |=> !pready) else $error("long ready");
	a_pull_out: assert property ((pads[0].pull & ~pads[0].oe_n) == 8'h00) else $error("pull");
	a_no_pull: assert property (pads[1].pull == 8'h00) else $error("B pull");
	a_c_top: assert property (pads[2].oe_n[7]) else $error("C top");
	a_e_top: assert property (&pads[4].oe_n[7:6]) else $error("E top");
	a_dir_rst: assert property ($rose(presetn) |-> &pads[0].oe_n) else $error("A dir");
	a_pue_rst: assert property ($rose(presetn) |-> pads[3].pull == 8'h00) else $error("D pue");
	cover property (pready);
	cover property (pads[0].pull != 8'h00);
	cover property (!pads[3].oe_n[0]);
endmodule : pio_ports_chk
bind pio_ports pio_ports_chk chk_u (.*);
`default_nettype wire

/* File: parallel_io_ports_bench.sv */
`default_nettype none
`define CK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module parallel_io_ports_bench;
	timeunit 1ns / 1ps;
	import pio_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [3:0] pstrb = 4'h1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [39:0] ext = 40'h0, pin_in;
	logic [4:0][7:0] lat, dir = 40'h0, pue = 40'h0;
	pio_pad_s [4:0] pads;
	int fail_count = 0, comparisons = 0;
	initial forever #4 pclk = ~pclk;
	pio_ports dut_u (.*);
	pio_pins pin_u (.*);
	task automatic bus(input logic w, input int i);
		int n = 0, e = -1, d = $urandom;
		for (int p = 0; p < 5; p++)
		begin
			// A write with the low byte strobe clear must leave every register alone
			if (w && d[9] && i == PIO_DATA_IDX[p]) lat[p] = d[7:0] & PIO_MASK[p];
			if (w && d[9] && i == PIO_DIR_IDX[p]) dir[p] = d[7:0] & PIO_MASK[p];
			if (w && d[9] && PIO_HAS_PUE[p] && i == PIO_PUE_IDX[p])
				pue[p] = d[7:0] & PIO_MASK[p];
			if (i == PIO_DATA_IDX[p]) e = PIO_MASK[p] & (dir[p] & lat[p] | ~dir[p]
				& (pue[p] & {8{PIO_HAS_PUE[p]}} | ext[p*8+:8])) | PIO_DATA_SET[p];
			if (i == PIO_DIR_IDX[p]) e = dir[p];
			if (PIO_HAS_PUE[p] && i == PIO_PUE_IDX[p]) e = pue[p];
		end
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= 12'(i * 4);
		pwdata <= d;
		pstrb <= {3'h0, d[9]};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		`CK("pready", 1'b1, pready)
		if (n == 20) give_verdict();
		`CK("pslverr", e < 0, pslverr)
		if (!w) `CK("prdata", e < 0 ? 0 : e, prdata)
		psel <= 0;
		penable <= 0;
	endtask : bus
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	initial
	begin
		void'($urandom(32'h68d741b7));
		repeat (5) @(posedge pclk);
		for (int k = 0; k < 9; k++)
		begin
			presetn <= k != 4;
			if (k == 4) {dir, pue} = 80'h0;
			ext <= 40'({$urandom, $urandom});
			repeat (4) @(posedge pclk);
			presetn <= 1;
			// Reads open on non-pin registers so the pin synchroniser settles after reset
			for (int i = 0; i < 17; i++)
				bus(k[0], (i + (k[0] ? 0 : 9)) % 17);
			// Pad controls settle at the edge that ends the last access
			@(posedge pclk);
			for (int p = 0; p < 5; p++)
			begin
				`CK("oe_n", ~dir[p], pads[p].oe_n)
				`CK("pull", pue[p] & ~dir[p] & {8{PIO_HAS_PUE[p]}}, pads[p].pull)
			end
		end
		give_verdict();
	end
endmodule : parallel_io_ports_bench
`default_nettype wire
